// *** panel_pixel_format_select_test.sv ***
/*
 * Self-checking bench for pfs_top with a flat panel model on its pins.
 * Assumes pfs_top_checker and pfs_panel_model are compiled before it.
 */
`timescale 1ns/1ps
`include "pfs_regs.svh"

module panel_pixel_format_select_test;
    import pfs_pkg::*;

    localparam logic [17:0] PIX_A = 18'h2AD4C;
    localparam logic [17:0] PIX_B = 18'h2003F;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        pixel_dot_clock, panel_shift_clock;
    logic [11:0] paddr, lower_half_data_pins, upper_half_data_pins, cap_lower, cap_upper;
    logic [31:0] pwdata, prdata, rd;
    pfs_pixel_t  pixel_in;
    int          fails, tests_run, per_0, per_1, per_2, edges, e0;

    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    initial
    begin
        pixel_dot_clock = 1'b0;
        #7;
        forever #16 pixel_dot_clock = ~pixel_dot_clock;
    end

    pfs_top u_dut
    (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .pixel_dot_clock(pixel_dot_clock), .pixel_in(pixel_in),
        .panel_shift_clock(panel_shift_clock), .lower_half_data_pins(lower_half_data_pins),
        .upper_half_data_pins(upper_half_data_pins)
    );

    pfs_panel_model u_panel
    (
        .rst_n(presetn), .panel_shift_clock(panel_shift_clock),
        .lower_half_data_pins(lower_half_data_pins), .upper_half_data_pins(upper_half_data_pins),
        .per_0(per_0), .per_1(per_1), .per_2(per_2), .edges(edges),
        .cap_lower(cap_lower), .cap_upper(cap_upper)
    );

    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one apb transfer; pready, read data and error are taken at one rising edge
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        chk(n, 2);
    endtask

    task automatic wait_idle;
        int n;
        n = 0;
        do
        begin
            apb(`PFS_STAT_OFFSET, 1'b0, 32'h0);
            n++;
        end
        while (rd[0] !== 1'b0 && n < 20);
        chk({31'h0, rd[0]}, 32'h0);
        repeat (40) @(posedge pixel_dot_clock);
    endtask

    task automatic t_regs;
        apb(`PFS_CFG_OFFSET, 1'b0, 32'h0);
        chk(rd, `PFS_CFG_RESET);
        apb(`PFS_CFG_OFFSET, 1'b1, 32'hFFFFFFFF);
        apb(`PFS_STAT_OFFSET, 1'b1, 32'h0);
        chk({31'h0, err}, 32'h0);
        apb(`PFS_CFG_OFFSET, 1'b0, 32'h0);
        chk(rd, 32'h003F0000);
        apb(`PFS_STAT_OFFSET, 1'b0, 32'h0);
        chk({28'h0, rd[4:1]}, 32'h0);
        apb(12'h400, 1'b1, 32'h1);
        chk({31'h0, err}, 32'h1);
        apb(12'h400, 1'b0, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000);
        $display("register test done");
    endtask

    task automatic t_mode(input logic [1:0] pt, input logic mo, input logic [2:0] fm,
                          input logic [2:0] ra, input int dots, input logic [17:0] pix,
                          input logic [11:0] lo, input logic [11:0] up);
        @(posedge pixel_dot_clock);
        pixel_in <= {1'b1, pix};
        apb(`PFS_CFG_OFFSET, 1'b1, {10'h0, pt, mo, fm, 16'h0});
        apb(`PFS_STAT_OFFSET, 1'b0, 32'h0);
        chk({28'h0, rd[4:1]}, {28'h0, ra, 1'b1});
        wait_idle();
        if (dots == 0)
        begin
            chk(per_0 + per_1 + per_2, 256);
            chk({31'h0, per_0 == 64 || per_0 == 96}, 32'h1);
        end
        else
        begin
            chk(per_0, dots * 32);
            chk(per_1 + per_2, dots * 64);
        end
        chk({8'h0, cap_lower, cap_upper}, {8'h0, lo, up});
        $display("mode test done type %h mono %h format %h", pt, mo, fm);
    endtask

    task automatic t_refuse(input logic [1:0] pt, input logic mo, input logic [2:0] fm);
        apb(`PFS_CFG_OFFSET, 1'b1, {10'h0, pt, mo, fm, 16'h0});
        apb(`PFS_STAT_OFFSET, 1'b0, 32'h0);
        chk({28'h0, rd[4:1]}, 32'h0);
        wait_idle();
        e0 = edges;
        repeat (20) @(posedge pixel_dot_clock);
        @(negedge pixel_dot_clock);
        chk(edges, e0);
        chk({8'h0, lower_half_data_pins, upper_half_data_pins}, 32'h0);
        $display("refusal test done type %h mono %h format %h", pt, mo, fm);
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////
    initial
    begin
        #500000;
        fails++;
        $display("watchdog expired");
        report_and_stop();
    end

    initial
    begin
        presetn   = 1'b0;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 12'h000;
        pwdata    = 32'h0;
        pixel_in  = '0;
        fails     = 0;
        tests_run = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_mode(2'h0, 1'b1, 3'h0, RATIO_4, 4, PIX_A, 12'hFFF, 12'hFFF);
        t_mode(2'h1, 1'b0, 3'h0, RATIO_1, 1, PIX_A, 12'hD4C, 12'hA80);
        t_mode(2'h0, 1'b0, 3'h1, RATIO_323, 0, PIX_B, 12'hB6D, 12'hB6D);
        t_mode(2'h0, 1'b1, 3'h1, RATIO_8, 8, PIX_A, 12'hFFF, 12'hFFF);
        t_mode(2'h1, 1'b0, 3'h1, RATIO_2, 2, PIX_A, 12'hAD3, 12'hAD3);
        t_mode(2'h0, 1'b0, 3'h2, RATIO_4, 4, PIX_B, 12'hB6D, 12'hB6D);
        t_mode(2'h0, 1'b0, 3'h3, RATIO_4, 4, PIX_B, 12'hB6D, 12'hB6D);
        t_refuse(2'h0, 1'b0, 3'h0);
        t_refuse(2'h0, 1'b1, 3'h2);
        for (int f = 4; f < 8; f++)
            t_refuse(2'h0, 1'b0, 3'(f));
        t_refuse(2'h2, 1'b0, 3'h0);
        t_refuse(2'h3, 1'b0, 3'h1);
        report_and_stop();
    end
endmodule

bind pfs_top pfs_top_checker u_chk
(
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .pixel_dot_clock(pixel_dot_clock), .pixel_in(pixel_in),
    .panel_shift_clock(panel_shift_clock), .lower_half_data_pins(lower_half_data_pins),
    .upper_half_data_pins(upper_half_data_pins)
);

// *** pfs_panel_model.sv ***
/*
 * Behavioural flat panel: times the shift clock and latches the data pins.
 * Assumes it only watches the reset and the panel pins of pfs_top; it drives nothing back.
 */
`timescale 1ns/1ps

module pfs_panel_model
(
    // reset
    input wire logic        rst_n,
    // panel pins
    input wire logic        panel_shift_clock,
    input wire logic [11:0] lower_half_data_pins,
    input wire logic [11:0] upper_half_data_pins,
    // observations
    output int              per_0,
    output int              per_1,
    output int              per_2,
    output int              edges,
    output logic [11:0]     cap_lower,
    output logic [11:0]     cap_upper
);
    realtime last_rise;

    // last three shift periods in ns, newest first
    always @(posedge panel_shift_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            per_0     <= 0;
            per_1     <= 0;
            per_2     <= 0;
            edges     <= 0;
            last_rise <= 0.0;
        end
        else
        begin
            per_0     <= int'($realtime - last_rise);
            per_1     <= per_0;
            per_2     <= per_1;
            edges     <= edges + 1;
            last_rise <= $realtime;
        end
    end

    ////////////////////////////////////////////////////////////
    // latch on the falling edge, mid-period, where the pins have settled
    always @(negedge panel_shift_clock)
    begin
        cap_lower <= lower_half_data_pins;
        cap_upper <= upper_half_data_pins;
    end
endmodule

// *** pfs_pkg.sv ***
/*
 * Types shared by the panel pixel format select modules.
 * Assumes pfs_regs.svh for the numeric constants.
 */
package pfs_pkg;

    // shift clock ratio to the dot clock
    typedef enum logic [2:0]
    {
        RATIO_OFF = 3'h0,
        RATIO_1   = 3'h1,
        RATIO_2   = 3'h2,
        RATIO_4   = 3'h3,
        RATIO_8   = 3'h4,
        RATIO_323 = 3'h5
    } pfs_ratio_t;

    // resolved panel mode
    typedef struct packed
    {
        logic       valid;
        pfs_ratio_t ratio;
        logic       tft;
        logic       two_ppc;
        logic       mono;
        logic       dual;
    } pfs_mode_t;

    // one pixel from the upstream stream, 6:6:6
    typedef struct packed
    {
        logic       valid;
        logic [5:0] red;
        logic [5:0] green;
        logic [5:0] blue;
    } pfs_pixel_t;

    // configuration word carried across the clock domains
    typedef struct packed
    {
        logic [1:0] ptype;
        logic       mono;
        logic [2:0] fmt;
    } pfs_cfg_t;

    // four-phase handshake sender states
    typedef enum logic [1:0]
    {
        HS_IDLE = 2'b00,
        HS_REQ  = 2'b01,
        HS_DROP = 2'b11
    } pfs_hs_state_t;

endpackage

// *** pfs_regs.svh ***
/*
 * Register map, field positions and reset values of the panel
 * pixel format select block.
 * Assumes inclusion by bare name from the bench and the modules.
 */
`ifndef PFS_REGS_SVH
`define PFS_REGS_SVH

// apb address width and register byte offsets
`define PFS_ADDR_W        12
`define PFS_CFG_OFFSET    12'h404
`define PFS_STAT_OFFSET   12'h408

// panel_timing_config_two fields
`define PFS_CFG_RESET     32'h00000000
`define PFS_FMT_LSB       16
`define PFS_FMT_MSB       18
`define PFS_MONO_BIT      19
`define PFS_PTYPE_LSB     20
`define PFS_PTYPE_MSB     21

// panel_type_field encodings
`define PFS_PTYPE_STN     2'h0
`define PFS_PTYPE_TFT     2'h1

// output-format encodings
`define PFS_FMT_8         3'h0
`define PFS_FMT_16        3'h1
`define PFS_FMT_24        3'h2
`define PFS_FMT_8SS       3'h3

// status register fields
`define PFS_STAT_BUSY     0
`define PFS_STAT_VALID    1
`define PFS_STAT_RAT_LSB  2
`define PFS_STAT_RAT_MSB  4

`endif

// *** pfs_shift_div.sv ***
/*
 * Shift clock divider running on the dot clock.
 * Assumes a ratio request that is stable for several dot clocks.
 */
`timescale 1ns/1ps
`include "pfs_regs.svh"

module pfs_shift_div
(
    // dot clock domain
    input  wire logic                clk,
    input  wire logic                rst_n,
    // ratio request
    input  wire pfs_pkg::pfs_ratio_t ratio_req,
    // divider outputs
    output pfs_pkg::pfs_ratio_t      ratio_q,
    output logic                     shift_q,
    output logic                     period_end
);
    import pfs_pkg::*;

    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [3:0] len;
    logic [1:0] phase_q;
    logic [1:0] phase_d;
    logic       shift_d;
    logic       swap;

    // dot clocks in the current shift period
    function automatic logic [3:0] period_len
    (
        input pfs_ratio_t r,
        input logic [1:0] ph
    );
        case (r)
            RATIO_2:   period_len = 4'h2;
            RATIO_4:   period_len = 4'h4;
            RATIO_8:   period_len = 4'h8;
            RATIO_323: period_len = (ph == 2'h1) ? 4'h2 : 4'h3;
            default:   period_len = 4'h1;
        endcase
    endfunction

    assign len        = period_len(ratio_q, phase_q);
    assign period_end = (cnt_q == len - 4'h1);
    assign swap       = period_end && (ratio_req != ratio_q);
    assign cnt_d      = period_end ? 4'h0 : cnt_q + 4'h1;
    assign phase_d    = swap ? 2'h0
                      : !period_end ? phase_q
                      : (phase_q == 2'h2) ? 2'h0 : phase_q + 2'h1;
    // high for the first len/2 dot clocks, rounded down, low for the rest: no runt at a swap
    assign shift_d    = (cnt_q < {1'b0, len[3:1]});

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q   <= 4'h0;
            phase_q <= 2'h0;
            shift_q <= 1'b0;
            ratio_q <= RATIO_OFF;
        end
        else
        begin
            cnt_q   <= cnt_d;
            phase_q <= phase_d;
            shift_q <= shift_d;
            if (swap)
            begin
                ratio_q <= ratio_req;
            end
        end
    end

endmodule

// *** pfs_top.sv ***
/*
 * Panel pixel format select: apb register, configuration crossing
 * into the dot clock domain, shift clock generation and pixel packing
 * onto the lower and upper panel data pins.
 * Assumes the pixel stream is produced on pixel_dot_clock and that
 * presetn is asserted long enough to reach both domains.
 */
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "pfs_regs.svh"


module pfs_top
(
    // apb slave
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic [`PFS_ADDR_W-1:0]   paddr,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [31:0]              pwdata,
    output logic                          pready,
    output logic [31:0]                   prdata,
    output logic                          pslverr,
    // pixel stream on the dot clock
    input  wire logic                     pixel_dot_clock,
    input  wire pfs_pkg::pfs_pixel_t      pixel_in,
    // panel pins
    output logic                          panel_shift_clock,
    output logic [11:0]                   lower_half_data_pins,
    output logic [11:0]                   upper_half_data_pins
);
    import pfs_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // mode decode, shared by both domains

    function automatic pfs_mode_t decode_mode(input pfs_cfg_t c);
        pfs_mode_t m;
        m = '0;
        m.ratio = RATIO_OFF;
        m.mono  = c.mono;
        if (c.ptype == `PFS_PTYPE_STN)
        begin
            m.dual = (c.fmt != `PFS_FMT_8SS);
            if (c.fmt == `PFS_FMT_8 && c.mono)
            begin
                m.valid = 1'b1;
                m.ratio = RATIO_4;
            end
            else if (c.fmt == `PFS_FMT_16)
            begin
                m.valid = 1'b1;
                m.ratio = c.mono ? RATIO_8 : RATIO_323;
            end
            else if (c.fmt == `PFS_FMT_24 && !c.mono)
            begin
                m.valid = 1'b1;
                m.ratio = RATIO_4;
            end
            else if (c.fmt == `PFS_FMT_8SS && !c.mono)
            begin
                m.valid = 1'b1;
                m.ratio = RATIO_4;
            end
        end
        else if (c.ptype == `PFS_PTYPE_TFT && !c.mono)
        begin
            m.tft = 1'b1;
            if (c.fmt == `PFS_FMT_8)
            begin
                m.valid = 1'b1;
                m.ratio = RATIO_1;
            end
            else if (c.fmt == `PFS_FMT_16)
            begin
                m.valid   = 1'b1;
                m.two_ppc = 1'b1;
                m.ratio   = RATIO_2;
            end
        end
        // unsupported or reserved settings leave the panel idle
        if (!m.valid)
        begin
            m = '0;
            m.ratio = RATIO_OFF;
        end
        return m;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // apb register access

    pfs_cfg_t      cfg_q;
    logic          pready_q;
    logic [31:0]   prdata_q;
    logic          pslverr_q;
    logic          dirty_q;
    pfs_hs_state_t hs_q;
    pfs_cfg_t      hs_word_q;
    logic          hs_req_q;
    logic          ack_s1_q;
    logic          ack_s2_q;
    logic          ack_q;

    wire           sel_cfg   = (paddr == `PFS_CFG_OFFSET);
    wire           sel_stat  = (paddr == `PFS_STAT_OFFSET);
    wire           mapped    = sel_cfg || sel_stat;
    wire           access    = psel && penable;
    wire           answer    = access && !pready_q;
    wire           done      = access && pready_q;
    wire           cfg_write = done && pwrite && sel_cfg;
    wire           hs_load   = (hs_q == HS_IDLE) && dirty_q;
    wire           busy      = dirty_q || (hs_q != HS_IDLE);
    wire pfs_mode_t cfg_mode = decode_mode(cfg_q);

    wire [31:0]    cfg_word  = {10'h000, cfg_q.ptype, cfg_q.mono,
                                cfg_q.fmt, 16'h0000};
    wire [31:0]    stat_word = {27'h0000000, cfg_mode.ratio,
                                cfg_mode.valid, busy};
    wire [31:0]    rd_word   = sel_cfg  ? cfg_word
                             : sel_stat ? stat_word
                             : 32'h00000000;

    // one wait state: pready rises in the second access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h00000000;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q  <= answer;
            pslverr_q <= answer && !mapped;
            prdata_q  <= (answer && !pwrite) ? rd_word : 32'h00000000;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_q <= pfs_cfg_t'(6'(`PFS_CFG_RESET >> `PFS_FMT_LSB));
        end
        else if (cfg_write)
        begin
            cfg_q.fmt   <= pwdata[`PFS_FMT_MSB:`PFS_FMT_LSB];
            cfg_q.mono  <= pwdata[`PFS_MONO_BIT];
            cfg_q.ptype <= pwdata[`PFS_PTYPE_MSB:`PFS_PTYPE_LSB];
        end
    end

    assign pready  = pready_q;
    assign prdata  = prdata_q;
    assign pslverr = pslverr_q;

    ////////////////////////////////////////////////////////////////////
    // configuration handshake, pclk side

    // a new write wins over the clear of the load
    wire dirty_d = cfg_write || (dirty_q && !hs_load);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dirty_q   <= 1'b1;
            hs_q      <= HS_IDLE;
            hs_word_q <= pfs_cfg_t'(6'(`PFS_CFG_RESET >> `PFS_FMT_LSB));
            hs_req_q  <= 1'b0;
            ack_s1_q  <= 1'b0;
            ack_s2_q  <= 1'b0;
        end
        else
        begin
            dirty_q  <= dirty_d;
            ack_s1_q <= ack_q;
            ack_s2_q <= ack_s1_q;
            case (hs_q)
                HS_IDLE:
                begin
                    if (dirty_q)
                    begin
                        hs_word_q <= cfg_q;
                        hs_req_q  <= 1'b1;
                        hs_q      <= HS_REQ;
                    end
                end
                HS_REQ:
                begin
                    if (ack_s2_q)
                    begin
                        hs_req_q <= 1'b0;
                        hs_q     <= HS_DROP;
                    end
                end
                HS_DROP:
                begin
                    if (!ack_s2_q)
                    begin
                        hs_q <= HS_IDLE;
                    end
                end
                default:
                begin
                    hs_q <= HS_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // dot clock domain: reset release and configuration capture

    logic [1:0] drst_q;
    logic       req_s1_q;
    logic       req_s2_q;
    pfs_cfg_t   dot_cfg_q;
    pfs_mode_t  app_mode_q;

    wire        dot_rst_n = drst_q[1];

    always_ff @(posedge pixel_dot_clock or negedge presetn)
    begin
        if (!presetn)
        begin
            drst_q <= 2'b00;
        end
        else
        begin
            drst_q <= {drst_q[0], 1'b1};
        end
    end

    // hs_word_q is stable while the request is high
    always_ff @(posedge pixel_dot_clock or negedge dot_rst_n)
    begin
        if (!dot_rst_n)
        begin
            req_s1_q  <= 1'b0;
            req_s2_q  <= 1'b0;
            ack_q     <= 1'b0;
            dot_cfg_q <= pfs_cfg_t'(6'(`PFS_CFG_RESET >> `PFS_FMT_LSB));
        end
        else
        begin
            req_s1_q <= hs_req_q;
            req_s2_q <= req_s1_q;
            ack_q    <= req_s2_q;
            if (req_s2_q && !ack_q)
            begin
                dot_cfg_q <= hs_word_q;
            end
        end
    end

    wire pfs_mode_t dot_mode = decode_mode(dot_cfg_q);

    ////////////////////////////////////////////////////////////////////
    // shift clock

    pfs_ratio_t div_ratio;
    logic       div_shift;
    logic       period_end;
    logic       pass_q;

    pfs_shift_div u_div
    (
        .clk        (pixel_dot_clock),
        .rst_n      (dot_rst_n),
        .ratio_req  (dot_mode.ratio),
        .ratio_q    (div_ratio),
        .shift_q    (div_shift),
        .period_end (period_end)
    );

    // select changes while the dot clock is low and the divided clock is low
    always_ff @(negedge pixel_dot_clock or negedge dot_rst_n)
    begin
        if (!dot_rst_n)
        begin
            pass_q <= 1'b0;
        end
        else
        begin
            pass_q <= (div_ratio == RATIO_1);
        end
    end

    // full-rate tft mode passes the dot clock itself
    assign panel_shift_clock = pass_q ? pixel_dot_clock : div_shift;

    ////////////////////////////////////////////////////////////////////
    // pixel packing

    logic [23:0] pack_q;
    logic [11:0] first_q;
    logic        pair_q;
    logic [11:0] lower_q;
    logic [11:0] upper_q;

    wire [2:0]  colour_bits = {pixel_in.red[5], pixel_in.green[5], pixel_in.blue[5]};
    wire [11:0] pix12       = {pixel_in.red[5:2], pixel_in.green[5:2],
                               pixel_in.blue[5:2]};
    wire [23:0] pack_d      = app_mode_q.mono ? {pack_q[22:0], pixel_in.green[5]}
                                              : {pack_q[20:0], colour_bits};

    always_ff @(posedge pixel_dot_clock or negedge dot_rst_n)
    begin
        if (!dot_rst_n)
        begin
            app_mode_q <= '0;
            pack_q     <= 24'h000000;
            first_q    <= 12'h000;
            pair_q     <= 1'b0;
            lower_q    <= 12'h000;
            upper_q    <= 12'h000;
        end
        else
        begin
            // data format follows the divider's ratio swap
            if (period_end)
            begin
                app_mode_q <= dot_mode;
            end
            if (!app_mode_q.valid)
            begin
                pair_q  <= 1'b0;
                lower_q <= 12'h000;
                upper_q <= 12'h000;
            end
            else if (app_mode_q.tft && !app_mode_q.two_ppc)
            begin
                if (pixel_in.valid)
                begin
                    lower_q <= {pixel_in.green, pixel_in.blue};
                    upper_q <= {pixel_in.red, 6'h00};
                end
            end
            else if (app_mode_q.tft)
            begin
                if (pixel_in.valid)
                begin
                    pair_q <= !pair_q;
                    if (!pair_q)
                    begin
                        first_q <= pix12;
                    end
                    else
                    begin
                        upper_q <= first_q;
                        lower_q <= pix12;
                    end
                end
            end
            else
            begin
                if (pixel_in.valid)
                begin
                    pack_q <= pack_d;
                end
                if (period_end)
                begin
                    upper_q <= pack_q[23:12];
                    lower_q <= pack_q[11:0];
                end
            end
        end
    end

    assign lower_half_data_pins = lower_q;
    assign upper_half_data_pins = upper_q;

endmodule

// *** pfs_top_checker.sv ***
/*
 * Concurrent checks on the apb side of pfs_top.
 * Assumes it is bound to pfs_top by the bench and that all checks run on pclk.
 */
`timescale 1ns/1ps
`include "pfs_regs.svh"

module pfs_top_checker
(
    // apb slave
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire logic [`PFS_ADDR_W-1:0] paddr,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [31:0]            pwdata,
    input wire logic                   pready,
    input wire logic [31:0]            prdata,
    input wire logic                   pslverr,
    // pixel stream
    input wire logic                   pixel_dot_clock,
    input wire pfs_pkg::pfs_pixel_t    pixel_in,
    // panel pins
    input wire logic                   panel_shift_clock,
    input wire logic [11:0]            lower_half_data_pins,
    input wire logic [11:0]            upper_half_data_pins
);
    import pfs_pkg::*;

    logic [5:0] cfg_q;
    logic [5:0] cfg_d;
    logic       done_w;
    logic       rd_cfg;
    logic       rd_stat;
    logic [2:0] exp_ratio;

    // ratio of a {type, mono, format} setting, 7 where the choice is left open
    function automatic logic [2:0] ratio_of(input logic [5:0] c);
        case (c)
            6'h08, 6'h02, 6'h03: return RATIO_4;
            6'h10:               return RATIO_1;
            6'h01:               return RATIO_323;
            6'h09:               return RATIO_8;
            6'h11:               return RATIO_2;
            6'h0B, 6'h12, 6'h13: return 3'h7;
            default:             return RATIO_OFF;
        endcase
    endfunction

    assign done_w    = psel && penable && pready;
    assign rd_cfg    = done_w && !pwrite && (paddr == `PFS_CFG_OFFSET);
    assign rd_stat   = done_w && !pwrite && (paddr == `PFS_STAT_OFFSET);
    assign cfg_d     = (done_w && pwrite && (paddr == `PFS_CFG_OFFSET)) ? pwdata[21:16] : cfg_q;
    assign exp_ratio = ratio_of(cfg_q);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cfg_q <= 6'h00;
        else
            cfg_q <= cfg_d;
    end

    ////////////////////////////////////////////////////////////
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_one_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_unmapped_err: assert property (done_w && paddr != `PFS_CFG_OFFSET
        && paddr != `PFS_STAT_OFFSET |-> pslverr && prdata == 32'h00000000)
        else $error("unmapped access not refused");
    chk_mapped_ok: assert property (done_w && (paddr == `PFS_CFG_OFFSET
        || paddr == `PFS_STAT_OFFSET) |-> !pslverr)
        else $error("mapped access refused");
    chk_cfg_fields: assert property (
        rd_cfg |-> prdata == {10'h000, cfg_q, 16'h0000})
        else $error("config readback differs");
    chk_stat_ratio: assert property (
        rd_stat && exp_ratio != 3'h7 |-> prdata[4:2] == exp_ratio)
        else $error("status ratio differs");
    chk_stat_valid: assert property (
        rd_stat && exp_ratio != 3'h7 |-> prdata[1] == (exp_ratio != RATIO_OFF))
        else $error("status valid differs");
    chk_stat_upper: assert property (rd_stat |-> prdata[31:5] == 27'h0000000)
        else $error("status upper bits set");
endmodule
